// ===== src/id_loader_defines.vh
/*
 * constants for the identity and control word two loader:
 * eeprom word addresses, field positions, defaults and register map.
 * assumes inclusion by bare name from the loader source.
 */
`ifndef ID_LOADER_DEFINES_VH
`define ID_LOADER_DEFINES_VH

// eeprom word addresses
`define EE_CTL1_ADDR         6'h0a
`define EE_SUBSYS_ADDR       6'h0b
`define EE_SUBVEN_ADDR       6'h0c
`define EE_DEVA_ADDR         6'h0d
`define EE_VEN_ADDR          6'h0e
`define EE_CTL2_ADDR         6'h0f
`define EE_DEVB_ADDR         6'h11

// control word one fields
`define CTL1_SIG_HI          15
`define CTL1_SIG_LO          14
`define CTL1_SIG_VALID       2'h1
`define CTL1_LOAD_SUBSYS     1
`define CTL1_LOAD_VENDEV     0

// control word two fields
`define CTL2_PME_BIT         15
`define CTL2_SPEED_DET_BIT   14
`define CTL2_PAUSE_HI        13
`define CTL2_PAUSE_LO        12
`define CTL2_AUTONEG_BIT     11
`define CTL2_FLASH_HI        10
`define CTL2_FLASH_LO        9
`define CTL2_MACCLK_BIT      8

// hardware defaults used when words are not loaded (arbitrary values)
`define DEF_SUBSYS           16'h0000
`define DEF_SUBVEN           16'h0000
`define DEF_DEVA             16'h0001
`define DEF_DEVB             16'h0002
`define DEF_VEN              16'h0003
`define DEF_CTL2             16'h0000

// transmit config word positions
`define XMIT_CFG_AUTONEG_BIT 31
`define XMIT_CFG_PAUSE_HI    8
`define XMIT_CFG_PAUSE_LO    7

// axi register byte offsets: printed offsets not multiples of four, so index*4
`define REG_SUBSYS_OFF       8'h2c
`define REG_SUBVEN_OFF       8'h30
`define REG_DEVA_OFF         8'h34
`define REG_VEN_OFF          8'h38
`define REG_CTL2_OFF         8'h3c
`define REG_DEVB_OFF         8'h44
`define REG_CTRL_OFF         8'h00
`define REG_STATUS_OFF       8'h04
`define REG_DERIVED_OFF      8'h08

// control register bits
`define CTRL_START_BIT       0
`define CTRL_DUAL_BIT        1
`define CTRL_FIBER_BIT       2

`endif

// ===== src/id_loader.v
/*
 * power-up loader of identity words and init control word two over a
 * simple word-read eeprom port, with an axi4-lite slave for the results.
 * assumes an eeprom reader that answers ee_req_o with ee_ack_i and data.
 */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "id_loader_defines.vh"

// Summary of operation
// - identity words used only with valid signature and load-subsystem bit
// - load word 0bh into subsystem identity when enabled
// - load word 0ch into subsystem vendor identity when enabled
// - dual port device takes first port device identity from word 0dh
// - dual port takes second port identity from 11h; single port ignores it
// - load word 0eh into vendor identity when enabled
// - fetch control word two at 0fh to set defaults and features
// - bit 15 sets initial pme-on-wakeup bit of wakeup control
// - pme init zero means deassert pme on wakeup
// - bit 14 sets initial auto speed detect enable
// - bits 13:12 copy to transmit config bits 8:7 pause advertisement
// - bit 11 copies to transmit config bit 31 autoneg enable
// - fiber implementations never auto enable autonegotiation
// - bits 10:9 encode flash size 64, 128, 256, 512 kb
// - decoded flash size sets flash and expansion rom bar size
// - bit 8 zero full mac speed, one quarter speed below gigabit
// - control word one bit 0 selects eeprom vendor/device identities
// - control word one bit 1 zero keeps default subsystem identities
module id_loader (
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	// eeprom word read port
	output reg         ee_req_o,
	output reg  [5:0]  ee_addr_o,
	input  wire        ee_ack_i,
	input  wire [15:0] ee_data_i,
	// loaded values to the rest of the controller
	output reg         cfg_done_o,
	output reg  [15:0] subsys_id_o,
	output reg  [15:0] subsys_ven_id_o,
	output reg  [15:0] dev_id_first_port_o,
	output reg  [15:0] dev_id_second_port_o,
	output reg  [15:0] ven_id_o,
	output reg         pme_on_pm_wakeup_init_o,
	output reg         pme_assert_on_wakeup_o,
	output reg         auto_speed_detect_enable_o,
	output reg         autoneg_enable_init_o,
	output reg  [1:0]  pause_adv_o,
	output reg  [19:0] flash_bar_mask_o,
	output reg         mac_quarter_clock_o,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// one-hot sequencer states
	localparam [7:0] ST_IDLE   = 8'h01;
	localparam [7:0] ST_CTL1   = 8'h02;
	localparam [7:0] ST_SUBSYS = 8'h04;
	localparam [7:0] ST_SUBVEN = 8'h08;
	localparam [7:0] ST_DEVA   = 8'h10;
	localparam [7:0] ST_VEN    = 8'h20;
	localparam [7:0] ST_CTL2   = 8'h40;
	localparam [7:0] ST_DEVB   = 8'h80;

	reg [7:0]  state_q;
	reg [15:0] ctl1_q;
	reg [15:0] ctl2_q;
	reg        dual_q;
	reg        fiber_q;
	reg        start_q;
	reg        busy_q;
	reg        aw_held_q;
	reg        w_held_q;
	reg [7:0]  awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;

	wire       sig_ok    = (ctl1_q[`CTL1_SIG_HI:`CTL1_SIG_LO] == `CTL1_SIG_VALID);
	wire       ld_subsys = sig_ok & ctl1_q[`CTL1_LOAD_SUBSYS];
	wire       ld_vendev = ld_subsys & ctl1_q[`CTL1_LOAD_VENDEV];
	wire       ee_take   = ee_req_o & ee_ack_i;

	// next fetch state after the current state, skipping disabled words
	function [7:0] next_state;
		input [7:0] cur;
		input       subs;
		input       vd;
		input       dual;
		begin
			case (cur)
			ST_CTL1: begin
				next_state = subs ? ST_SUBSYS : ST_CTL2;
			end
			ST_SUBSYS: begin
				next_state = ST_SUBVEN;
			end
			ST_SUBVEN: begin
				next_state = vd ? ST_DEVA : ST_CTL2;
			end
			ST_DEVA: begin
				next_state = ST_VEN;
			end
			ST_VEN: begin
				next_state = ST_CTL2;
			end
			ST_CTL2: begin
				next_state = (vd & dual) ? ST_DEVB : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
			endcase
		end
	endfunction

	function [5:0] addr_of;
		input [7:0] st;
		begin
			case (st)
			ST_CTL1:   addr_of = `EE_CTL1_ADDR;
			ST_SUBSYS: addr_of = `EE_SUBSYS_ADDR;
			ST_SUBVEN: addr_of = `EE_SUBVEN_ADDR;
			ST_DEVA:   addr_of = `EE_DEVA_ADDR;
			ST_VEN:    addr_of = `EE_VEN_ADDR;
			ST_CTL2:   addr_of = `EE_CTL2_ADDR;
			ST_DEVB:   addr_of = `EE_DEVB_ADDR;
			default:   addr_of = `EE_CTL1_ADDR;
			endcase
		end
	endfunction

	// control word one is only on the data lines at its own take, so the
	// branch after it must look at the incoming word, not the stored copy
	wire       sub_now   = (ee_data_i[`CTL1_SIG_HI:`CTL1_SIG_LO] == `CTL1_SIG_VALID) &
	                       ee_data_i[`CTL1_LOAD_SUBSYS];
	wire       subs_sel  = (state_q == ST_CTL1) ? sub_now : ld_subsys;

	wire [7:0] nxt = next_state(state_q, subs_sel, ld_vendev, dual_q);

	// word fetch sequencer; restart puts every value back to its default
	always @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_q              <= ST_CTL1;
			ee_req_o             <= 1'b1;
			ee_addr_o            <= `EE_CTL1_ADDR;
			busy_q               <= 1'b1;
			cfg_done_o           <= 1'b0;
			ctl1_q               <= 16'h0000;
			ctl2_q               <= `DEF_CTL2;
			subsys_id_o          <= `DEF_SUBSYS;
			subsys_ven_id_o      <= `DEF_SUBVEN;
			dev_id_first_port_o  <= `DEF_DEVA;
			dev_id_second_port_o <= `DEF_DEVB;
			ven_id_o             <= `DEF_VEN;
		end else if (start_q && !busy_q) begin
			state_q              <= ST_CTL1;
			ee_req_o             <= 1'b1;
			ee_addr_o            <= `EE_CTL1_ADDR;
			busy_q               <= 1'b1;
			cfg_done_o           <= 1'b0;
			ctl1_q               <= 16'h0000;
			ctl2_q               <= `DEF_CTL2;
			subsys_id_o          <= `DEF_SUBSYS;
			subsys_ven_id_o      <= `DEF_SUBVEN;
			dev_id_first_port_o  <= `DEF_DEVA;
			dev_id_second_port_o <= `DEF_DEVB;
			ven_id_o             <= `DEF_VEN;
		end else if (ee_take) begin
			case (state_q)
			ST_CTL1:   ctl1_q <= ee_data_i;
			ST_SUBSYS: subsys_id_o <= ee_data_i;
			ST_SUBVEN: subsys_ven_id_o <= ee_data_i;
			ST_DEVA:   dev_id_first_port_o <= ee_data_i;
			ST_VEN:    ven_id_o <= ee_data_i;
			ST_CTL2:   if (sig_ok) ctl2_q <= ee_data_i;
			ST_DEVB:   dev_id_second_port_o <= ee_data_i;
			default:   ctl1_q <= ctl1_q;
			endcase
			state_q   <= nxt;
			ee_addr_o <= addr_of(nxt);
			if (nxt == ST_IDLE) begin
				ee_req_o   <= 1'b0;
				busy_q     <= 1'b0;
				cfg_done_o <= 1'b1;
			end
		end
	end

	// decode of control word two into feature defaults
	always @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			pme_on_pm_wakeup_init_o    <= 1'b0;
			pme_assert_on_wakeup_o     <= 1'b0;
			auto_speed_detect_enable_o <= 1'b0;
			autoneg_enable_init_o      <= 1'b0;
			pause_adv_o                <= 2'h0;
			flash_bar_mask_o           <= 20'hf0000;
			mac_quarter_clock_o        <= 1'b0;
		end else begin
			pme_on_pm_wakeup_init_o    <= ctl2_q[`CTL2_PME_BIT];
			pme_assert_on_wakeup_o     <= ctl2_q[`CTL2_PME_BIT];
			auto_speed_detect_enable_o <= ctl2_q[`CTL2_SPEED_DET_BIT];
			pause_adv_o <= ctl2_q[`CTL2_PAUSE_HI:`CTL2_PAUSE_LO];
			autoneg_enable_init_o <= ctl2_q[`CTL2_AUTONEG_BIT] & ~fiber_q;
			// size mask: ones above the window, 64 kb .. 512 kb
			case (ctl2_q[`CTL2_FLASH_HI:`CTL2_FLASH_LO])
			2'h0:    flash_bar_mask_o <= 20'hf0000;
			2'h1:    flash_bar_mask_o <= 20'he0000;
			2'h2:    flash_bar_mask_o <= 20'hc0000;
			default: flash_bar_mask_o <= 20'h80000;
			endcase
			mac_quarter_clock_o <= ctl2_q[`CTL2_MACCLK_BIT];
		end
	end

	// axi write path: address and data taken in either order
	wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;

	always @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			start_q       <= 1'b0;
			dual_q        <= 1'b0;
			fiber_q       <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_held_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_held_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == `REG_CTRL_OFF) begin
					s_axi_bresp <= 2'h0;
					if (wstrb_q[0]) begin
						start_q <= wdata_q[`CTRL_START_BIT];
						dual_q  <= wdata_q[`CTRL_DUAL_BIT];
						fiber_q <= wdata_q[`CTRL_FIBER_BIT];
					end
				end else begin
					s_axi_bresp <= 2'h2; // identity words are read only
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// axi read path, one outstanding read
	always @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			case (s_axi_araddr)
			`REG_CTRL_OFF:    s_axi_rdata <= {29'h0, fiber_q, dual_q, 1'b0};
			`REG_STATUS_OFF:  s_axi_rdata <= {22'h0, state_q, busy_q, cfg_done_o};
			`REG_DERIVED_OFF: s_axi_rdata <= {5'h0, flash_bar_mask_o,
				mac_quarter_clock_o, autoneg_enable_init_o, pause_adv_o,
				auto_speed_detect_enable_o, pme_on_pm_wakeup_init_o, sig_ok};
			`REG_SUBSYS_OFF:  s_axi_rdata <= {16'h0, subsys_id_o};
			`REG_SUBVEN_OFF:  s_axi_rdata <= {16'h0, subsys_ven_id_o};
			`REG_DEVA_OFF:    s_axi_rdata <= {16'h0, dev_id_first_port_o};
			`REG_VEN_OFF:     s_axi_rdata <= {16'h0, ven_id_o};
			`REG_CTL2_OFF:    s_axi_rdata <= {16'h0, ctl2_q};
			`REG_DEVB_OFF:    s_axi_rdata <= {16'h0, dev_id_second_port_o};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ===== test/ee_model.sv
/* eeprom word-read model facing the loader.
   answers a request after 1 to 3 idle cycles; the bench fills mem. */
`timescale 1ns/10ps
`default_nettype none
module ee_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic [5:0]  addr_i,
	output logic             ack_o,
	output logic [15:0]      data_o
);
	logic [15:0] mem [64];
	int          wait_q = 0;
	// data is good only in the ack cycle, junk that toggles otherwise
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		data_o <= ~data_o;
		if (req_i && ack_o !== 1'b1) begin
			if (wait_q == 0) begin
				ack_o <= 1'b1;
				data_o <= mem[addr_i];
				wait_q <= $urandom % 3;
			end else begin
				wait_q <= wait_q - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/id_loader_props.sv
/* port checker for the loader's eeprom sequence and derived bits.
   one clock domain, synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module id_loader_props (
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	input wire logic        ee_req_o,
	input wire logic [5:0]  ee_addr_o,
	input wire logic        ee_ack_i,
	input wire logic [15:0] ee_data_i,
	input wire logic        cfg_done_o,
	input wire logic        pme_on_pm_wakeup_init_o,
	input wire logic        pme_assert_on_wakeup_o,
	input wire logic [1:0]  pause_adv_o,
	input wire logic [19:0] flash_bar_mask_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire       tk = ee_req_o && ee_ack_i;
	wire [1:0] sg = ee_data_i[15:14];
	logic      ok_q;
	// signature seen at the last control word one fetch
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i)
			ok_q <= 1'b0;
		else if (tk && ee_addr_o == 6'h0a)
			ok_q <= sg == 2'h1;
	end
	property p_ctl2;
		logic [15:0] d;
		(tk && ok_q && ee_addr_o == 6'h0f, d = ee_data_i) |-> ##2
			(pme_on_pm_wakeup_init_o == d[15] && pause_adv_o == d[13:12]);
	endproperty
	property p_pme;
		logic [15:0] d;
		(tk && ok_q && ee_addr_o == 6'h0f, d = ee_data_i) |-> ##2
			pme_assert_on_wakeup_o == d[15];
	endproperty
	property p_flash;
		logic [15:0] d;
		(tk && ok_q && ee_addr_o == 6'h0f, d = ee_data_i) |-> ##2
			flash_bar_mask_o == 20'(20'hfffff << (16 + d[10:9]));
	endproperty
	AST_BAD_SIG: assert property (tk && ee_addr_o == 6'h0a && sg != 2'h1 |=> ee_addr_o == 6'h0f)
		else $error("bad signature not skipped");
	AST_SUB_LOAD: assert property (tk && ee_addr_o == 6'h0a && sg == 2'h1 && ee_data_i[1] |=> ee_addr_o == 6'h0b)
		else $error("subsystem word not fetched");
	AST_SUB_SKIP: assert property (tk && ee_addr_o == 6'h0a && sg == 2'h1 && !ee_data_i[1] |=> ee_addr_o == 6'h0f)
		else $error("subsystem words not skipped");
	AST_SUBVEN: assert property (tk && ee_addr_o == 6'h0b |=> ee_addr_o == 6'h0c)
		else $error("subsystem vendor word not next");
	AST_DONE: assert property ($rose(cfg_done_o) |-> $past(tk) && !ee_req_o)
		else $error("done without final load");
	AST_CTL2: assert property (p_ctl2)
		else $error("control word two bits not applied");
	AST_FLASH: assert property (p_flash)
		else $error("flash mask wrong");
	AST_PME: assert property (p_pme)
		else $error("pme wakeup polarity wrong");
	C_DONE: cover property ($rose(cfg_done_o));
	C_DEVA: cover property (tk && ee_addr_o == 6'h0d);
	C_DEVB: cover property (tk && ee_addr_o == 6'h11);
endmodule
bind id_loader id_loader_props u_props (.*);
`default_nettype wire

// ===== test/tb.sv
/* self-checking bench for the loader: eeprom model on the word port,
   axi4-lite master tasks, reference values worked out per case. */
`timescale 1ns/10ps
`default_nettype none
`include "id_loader_defines.vh"
module tb;
	logic        sys_clk_i = 0, reset_n_i = 0, ee_req_o, ee_ack_i, cfg_done_o;
	logic [5:0]  ee_addr_o;
	logic [15:0] ee_data_i, subsys_id_o, subsys_ven_id_o, dev_id_first_port_o;
	logic [15:0] dev_id_second_port_o, ven_id_o;
	logic        pme_on_pm_wakeup_init_o, pme_assert_on_wakeup_o, auto_speed_detect_enable_o;
	logic        autoneg_enable_init_o, mac_quarter_clock_o;
	logic [1:0]  pause_adv_o, s_axi_bresp, s_axi_rresp;
	logic [19:0] flash_bar_mask_o;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          errors = 0, tests_run = 0;
	id_loader uut (.*);
	ee_model u_ee (.clk_i(sys_clk_i), .req_i(ee_req_o), .addr_i(ee_addr_o),
		.ack_o(ee_ack_i), .data_o(ee_data_i));
	always #2.5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// a wait that ran out counts as a mismatch and ends the run
	task automatic stall;
		errors++;
		complete_run;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) stall;
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) stall;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// eight loads: signatures 00, 01 and 10, every select case, every flash code
	initial begin
		logic [15:0] w1, v, ex[6];
		logic [7:0]  offs[6] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h44};
		logic [31:0] rd;
		logic [1:0]  rs;
		int          t, n, dual, fib, ok, sub, vd;
		void'($urandom(32'hfbc3));
		for (int i = 0; i < 8; i++) begin
			t = i % 4;
			dual = i / 4;
			fib = (i / 2) % 2;
			foreach (u_ee.mem[k]) u_ee.mem[k] = 16'($urandom);
			w1 = u_ee.mem[`EE_CTL1_ADDR];
			w1[15:14] = (t == 0) ? 2'(dual * 2) : 2'h1;
			w1[1] = t > 1;
			w1[0] = t % 2;
			u_ee.mem[`EE_CTL1_ADDR] = w1;
			u_ee.mem[`EE_CTL2_ADDR][10:9] = 2'(i);
			u_ee.mem[`EE_CTL2_ADDR][11] = 1'b1;
			if (i == 0) begin
				repeat (5) @(posedge sys_clk_i);
				reset_n_i <= 1;
			end else begin
				axw(`REG_CTRL_OFF, 32'(fib * 4 + dual * 2 + 1), rs);
				chk("ctrl_bresp", rs, 2'h0);
				for (n = 0; n < 20 && cfg_done_o; n++) @(posedge sys_clk_i);
				if (n == 20) stall;
			end
			for (n = 0; n < 300 && cfg_done_o !== 1'b1; n++) @(posedge sys_clk_i);
			if (n == 300) stall;
			ok = w1[15:14] == 2'h1;
			sub = ok && w1[1];
			vd = sub && w1[0];
			ex[0] = sub ? u_ee.mem[`EE_SUBSYS_ADDR] : `DEF_SUBSYS;
			ex[1] = sub ? u_ee.mem[`EE_SUBVEN_ADDR] : `DEF_SUBVEN;
			ex[2] = vd ? u_ee.mem[`EE_DEVA_ADDR] : `DEF_DEVA;
			ex[3] = vd ? u_ee.mem[`EE_VEN_ADDR] : `DEF_VEN;
			ex[4] = ok ? u_ee.mem[`EE_CTL2_ADDR] : `DEF_CTL2;
			ex[5] = (vd && dual) ? u_ee.mem[`EE_DEVB_ADDR] : `DEF_DEVB;
			for (int k = 0; k < 6; k++) begin
				axr(offs[k], rd, rs);
				chk("word_reg", rd, {16'h0, ex[k]});
			end
			axr(`REG_STATUS_OFF, rd, rs);
			chk("status_done", rd[0], 1'b1);
			v = ex[4];
			chk("subsys", subsys_id_o, ex[0]);
			chk("subven", subsys_ven_id_o, ex[1]);
			chk("dev_a", dev_id_first_port_o, ex[2]);
			chk("ven", ven_id_o, ex[3]);
			chk("dev_b", dev_id_second_port_o, ex[5]);
			chk("pme", {pme_on_pm_wakeup_init_o, pme_assert_on_wakeup_o}, {2{v[15]}});
			chk("speed_detect", auto_speed_detect_enable_o, v[14]);
			chk("pause", pause_adv_o, v[13:12]);
			chk("autoneg", autoneg_enable_init_o, v[11] & !fib);
			chk("flash", flash_bar_mask_o, 20'(20'hfffff << (16 + v[10:9])));
			chk("macclk", mac_quarter_clock_o, v[8]);
		end
		// refused write to a loaded word, then an unmapped read
		axw(`REG_SUBSYS_OFF, 32'hffff, rs);
		chk("ro_bresp", rs, 2'h2);
		axr(`REG_SUBSYS_OFF, rd, rs);
		chk("ro_kept", rd, {16'h0, ex[0]});
		axr(8'h80, rd, rs);
		chk("unmapped_rresp", rs, 2'h2);
		chk("unmapped_rdata", rd, 32'h0);
		complete_run;
	end
endmodule
`default_nettype wire
